// >>> core/cam_mem.sv
// Memory-block end: 32 words of 32 bits with per-bit care masks and search.
// Assumes the user end holds write address and data for the whole write.

`timescale 1ns/1ps
module cam_mem #(
  parameter cam_pkg::cam_word_t INIT_DATA [cam_pkg::DEPTH] = '{default: 32'h0000_0000},
  parameter cam_pkg::cam_word_t INIT_CARE [cam_pkg::DEPTH] = '{default: 32'h0000_0000}
) (
  cam_if.mem bus
);
  // ----------------------------------------
  // Storage
  // ----------------------------------------
  // Preload stands in for configuration; reset leaves the contents alone
  cam_pkg::cam_word_t data_r [cam_pkg::DEPTH] = INIT_DATA;
  cam_pkg::cam_word_t care_r [cam_pkg::DEPTH] = INIT_CARE;

  // Write side
  cam_pkg::cam_wr_e wst_r;
  cam_pkg::cam_addr_t waddr_r;
  logic masked_r;
  logic wr_take;
  logic commit;

  // Search side
  logic [cam_pkg::DEPTH-1:0] hit_vec;
  logic [cam_pkg::DEPTH:0] below;
  logic [cam_pkg::DEPTH-1:0] first_vec;
  cam_pkg::cam_addr_t addr_acc [cam_pkg::DEPTH+1];
  logic [cam_pkg::DEPTH-1:0] hold_r;
  cam_pkg::cam_srch_e sst_r;
  logic srch_take;
  logic unenc_take;

  // ----------------------------------------
  // Write sequencer
  // ----------------------------------------
  // A start is taken only from idle; one arriving mid-write is dropped
  assign wr_take = bus.wr_start && wst_r == cam_pkg::CAM_IDLE;
  // Commit lands on the last cycle so a search never sees a half-written word
  assign commit = (wst_r == cam_pkg::CAM_WR2 && !masked_r) || wst_r == cam_pkg::CAM_WR3;

  always_ff @(posedge bus.i_mclk) begin
    if (!bus.i_nrst) begin
      wst_r <= cam_pkg::CAM_IDLE;
    end else begin
      unique case (wst_r)
        cam_pkg::CAM_IDLE: begin
          if (wr_take) begin
            wst_r <= cam_pkg::CAM_WR1;
          end
        end
        cam_pkg::CAM_WR1: begin
          wst_r <= cam_pkg::CAM_WR2;
        end
        cam_pkg::CAM_WR2: begin
          wst_r <= masked_r ? cam_pkg::CAM_WR3 : cam_pkg::CAM_IDLE;
        end
        cam_pkg::CAM_WR3: begin
          wst_r <= cam_pkg::CAM_IDLE;
        end
      endcase
    end
  end

  // Location and mask kind latched at start; data is read at commit
  always_ff @(posedge bus.i_mclk) begin
    if (!bus.i_nrst) begin
      waddr_r <= '0;
      masked_r <= 1'b0;
    end else if (wr_take) begin
      waddr_r <= bus.wr_addr;
      masked_r <= ~&bus.wr_care;
    end
  end

  always_ff @(posedge bus.i_mclk) begin
    if (!bus.i_nrst) begin
      bus.wr_busy <= 1'b0;
    end else begin
      bus.wr_busy <= wr_take || (wst_r != cam_pkg::CAM_IDLE && !commit);
    end
  end

  // ----------------------------------------
  // Storage update
  // ----------------------------------------
  // Word and mask land together, so a search sees old or new, never a mix
  always_ff @(posedge bus.i_mclk) begin
    if (bus.i_nrst && commit) begin
      data_r[waddr_r] <= bus.wr_data;
      care_r[waddr_r] <= bus.wr_care;
    end
  end

  // ----------------------------------------
  // Parallel compare
  // ----------------------------------------
  assign below[0] = 1'b0;
  assign addr_acc[0] = '0;
  for (genvar g = 0; g < cam_pkg::DEPTH; g++) begin : g_entry
    // A cleared care bit drops out of the compare
    assign hit_vec[g] = ~|((data_r[g] ^ bus.srch_data) & care_r[g]);
    assign below[g+1] = below[g] | hit_vec[g];
    // Only the lowest hit survives; with duplicates the address is that of the lowest entry
    assign first_vec[g] = hit_vec[g] & ~below[g];
    assign addr_acc[g+1] = addr_acc[g] | (first_vec[g] ? cam_pkg::cam_addr_t'(g) : '0);
  end

  // ----------------------------------------
  // Search take
  // ----------------------------------------
  // An unencoded pair blocks new searches until its second half is out
  assign srch_take = bus.srch_start && sst_r == cam_pkg::CAM_S_IDLE;
  assign unenc_take = srch_take && bus.srch_mode == cam_pkg::OUT_UNENCODED;

  // ----------------------------------------
  // Result sequencer
  // ----------------------------------------
  always_ff @(posedge bus.i_mclk) begin
    if (!bus.i_nrst) begin
      sst_r <= cam_pkg::CAM_S_IDLE;
    end else begin
      unique case (sst_r)
        cam_pkg::CAM_S_IDLE: begin
          if (unenc_take) begin
            sst_r <= cam_pkg::CAM_S_LOW;
          end
        end
        cam_pkg::CAM_S_LOW: begin
          sst_r <= cam_pkg::CAM_S_HIGH;
        end
        cam_pkg::CAM_S_HIGH: begin
          sst_r <= cam_pkg::CAM_S_IDLE;
        end
        default: sst_r <= cam_pkg::CAM_S_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // Result outputs
  // ----------------------------------------
  // Upper half parked so a new key cannot disturb the second beat
  always_ff @(posedge bus.i_mclk) begin
    if (!bus.i_nrst) begin
      hold_r <= '0;
    end else if (unenc_take) begin
      hold_r <= hit_vec;
    end
  end

  always_ff @(posedge bus.i_mclk) begin
    if (!bus.i_nrst) begin
      bus.res_valid <= 1'b0;
    end else begin
      bus.res_valid <= srch_take || sst_r == cam_pkg::CAM_S_LOW;
    end
  end

  always_ff @(posedge bus.i_mclk) begin
    if (!bus.i_nrst) begin
      bus.res_hit <= 1'b0;
    end else if (srch_take) begin
      bus.res_hit <= |hit_vec;
    end
  end

  // Unencoded results carry no address
  always_ff @(posedge bus.i_mclk) begin
    if (!bus.i_nrst) begin
      bus.res_addr <= '0;
    end else if (unenc_take) begin
      bus.res_addr <= '0;
    end else if (srch_take) begin
      bus.res_addr <= addr_acc[cam_pkg::DEPTH];
    end
  end

  always_ff @(posedge bus.i_mclk) begin
    if (!bus.i_nrst) begin
      bus.res_lines <= '0;
    end else if (unenc_take) begin
      bus.res_lines <= hit_vec[cam_pkg::HALF-1:0];
    end else if (sst_r == cam_pkg::CAM_S_LOW) begin
      bus.res_lines <= hold_r[cam_pkg::DEPTH-1:cam_pkg::HALF];
    end else if (srch_take) begin
      bus.res_lines <= '0;
    end
  end

  always_ff @(posedge bus.i_mclk) begin
    if (!bus.i_nrst) begin
      bus.res_upper <= 1'b0;
    end else begin
      bus.res_upper <= sst_r == cam_pkg::CAM_S_LOW;
    end
  end
endmodule : cam_mem

// >>> core/cam_pkg.sv
// Shared constants and types for the content-addressable memory block.
// Assumes both ends and the interface use one clock and one reset.
package cam_pkg;
  // ----------------------------------------
  // Geometry
  // ----------------------------------------
  localparam int unsigned DEPTH = 32;
  localparam int unsigned WIDTH = 32;
  localparam int unsigned AW = 5;
  localparam int unsigned HALF = 16;
  // ----------------------------------------
  // Write timing in clock cycles
  // ----------------------------------------
  localparam logic [1:0] WR_CYC_PLAIN = 2'h2;
  localparam logic [1:0] WR_CYC_MASK = 2'h3;
  // ----------------------------------------
  // Output format select
  // ----------------------------------------
  localparam logic OUT_ENCODED = 1'h0;
  localparam logic OUT_UNENCODED = 1'h1;
  typedef logic [WIDTH-1:0] cam_word_t;
  typedef logic [AW-1:0] cam_addr_t;
  typedef enum logic [1:0] {
    CAM_IDLE = 2'h0,
    CAM_WR1 = 2'h1,
    CAM_WR2 = 2'h3,
    CAM_WR3 = 2'h2
  } cam_wr_e;
  typedef enum logic [1:0] {
    CAM_S_IDLE = 2'h0,
    CAM_S_LOW = 2'h1,
    CAM_S_HIGH = 2'h3
  } cam_srch_e;
endpackage : cam_pkg

// >>> core/cam_if.sv
// Connection between the memory block and the user logic that drives it.
// Assumes one clock and a synchronous active-low reset shared by both ends.
`timescale 1ns/1ps
interface cam_if (
  input wire logic i_mclk,
  input wire logic i_nrst
);
  logic wr_start;
  cam_pkg::cam_addr_t wr_addr;
  cam_pkg::cam_word_t wr_data;
  cam_pkg::cam_word_t wr_care;
  logic wr_busy;
  logic srch_start;
  logic srch_mode;
  cam_pkg::cam_word_t srch_data;
  logic res_valid;
  logic res_hit;
  cam_pkg::cam_addr_t res_addr;
  logic [cam_pkg::HALF-1:0] res_lines;
  logic res_upper;

  modport mem (
    input i_mclk, i_nrst, wr_start, wr_addr, wr_data, wr_care,
    input srch_start, srch_mode, srch_data,
    output wr_busy, res_valid, res_hit, res_addr, res_lines, res_upper
  );
  modport user (
    input i_mclk, i_nrst, wr_busy, res_valid, res_hit, res_addr, res_lines, res_upper,
    output wr_start, wr_addr, wr_data, wr_care, srch_start, srch_mode, srch_data
  );
endinterface : cam_if

// >>> core/cam_user.sv
// User-logic end: holds write fields for the full write and paces searches.
// Assumes the memory end sits on the same clock and reset.
`timescale 1ns/1ps
module cam_user (
  cam_if.user bus,
  input wire logic i_wr_req,
  input wire cam_pkg::cam_addr_t i_wr_addr,
  input wire cam_pkg::cam_word_t i_wr_data,
  input wire cam_pkg::cam_word_t i_wr_care,
  input wire logic i_srch_req,
  input wire logic i_srch_mode,
  input wire cam_pkg::cam_word_t i_srch_data,
  output logic o_ready,
  output logic o_res_valid,
  output logic o_res_hit,
  output cam_pkg::cam_addr_t o_res_addr,
  output logic [cam_pkg::HALF-1:0] o_res_lines,
  output logic o_res_upper
);
  logic busy;
  logic [1:0] srch_gap_r;
  assign busy = bus.wr_start || bus.wr_busy || bus.srch_start || srch_gap_r != 2'h0;

  // ----------------------------------------
  // Request launch; fields held until the next request
  // ----------------------------------------
  always_ff @(posedge bus.i_mclk) begin
    if (!bus.i_nrst) begin
      bus.wr_start <= 1'b0;
      bus.wr_addr <= '0;
      bus.wr_data <= '0;
      bus.wr_care <= '1;
      bus.srch_start <= 1'b0;
      bus.srch_mode <= cam_pkg::OUT_ENCODED;
      bus.srch_data <= '0;
      srch_gap_r <= 2'h0;
      o_ready <= 1'b0;
    end else begin
      bus.wr_start <= 1'b0;
      bus.srch_start <= 1'b0;
      if (srch_gap_r != 2'h0) begin
        srch_gap_r <= srch_gap_r - 2'h1;
      end
      if (o_ready && !busy && i_wr_req) begin
        bus.wr_start <= 1'b1;
        bus.wr_addr <= i_wr_addr;
        bus.wr_data <= i_wr_data;
        bus.wr_care <= i_wr_care;
      end else if (o_ready && !busy && i_srch_req) begin
        bus.srch_start <= 1'b1;
        bus.srch_mode <= i_srch_mode;
        bus.srch_data <= i_srch_data;
        // Unencoded result spans two cycles; do not overlap it
        srch_gap_r <= (i_srch_mode == cam_pkg::OUT_UNENCODED) ? 2'h2 : 2'h0;
      end
      o_ready <= !(i_wr_req || i_srch_req) && !busy;
    end
  end

  // ----------------------------------------
  // Result capture
  // ----------------------------------------
  always_ff @(posedge bus.i_mclk) begin
    if (!bus.i_nrst) begin
      o_res_valid <= 1'b0;
      o_res_hit <= 1'b0;
      o_res_addr <= '0;
      o_res_lines <= '0;
      o_res_upper <= 1'b0;
    end else begin
      o_res_valid <= bus.res_valid;
      o_res_hit <= bus.res_hit;
      o_res_addr <= bus.res_addr;
      o_res_lines <= bus.res_lines;
      o_res_upper <= bus.res_upper;
    end
  end
endmodule : cam_user

// >>> verif/cam_assertions.sv
// Timing checks on the link between the memory end and the user end.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ps
module cam_assertions (
  input wire logic i_mclk,
  input wire logic i_nrst,
  input wire logic wr_start,
  input wire cam_pkg::cam_addr_t wr_addr,
  input wire cam_pkg::cam_word_t wr_data,
  input wire cam_pkg::cam_word_t wr_care,
  input wire logic wr_busy,
  input wire logic srch_start,
  input wire logic srch_mode,
  input wire logic res_valid,
  input wire logic res_hit,
  input wire cam_pkg::cam_addr_t res_addr,
  input wire logic [cam_pkg::HALF-1:0] res_lines,
  input wire logic res_upper
);
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (!i_nrst);
  sequence lo_half_q;
    res_valid && !res_upper;
  endsequence
  sequence hi_half_q;
    res_valid && res_upper;
  endsequence
  plain_wr_len_a:
    assert property (wr_start && !wr_busy && (&wr_care) |=> wr_busy[*2] ##1 !wr_busy)
    else $error("plain write busy length wrong");
  mask_wr_len_a:
    assert property (wr_start && !wr_busy && !(&wr_care) |=> wr_busy[*3] ##1 !wr_busy)
    else $error("masked write busy length wrong");
  wr_fields_held_a:
    assert property (wr_busy |-> $stable(wr_addr) && $stable(wr_data) && $stable(wr_care))
    else $error("write fields moved during write");
  enc_result_a:
    assert property (srch_start && !srch_mode && !res_valid |=> lo_half_q ##1 !res_upper)
    else $error("encoded result timing wrong");
  unenc_halves_a:
    assert property (srch_start && srch_mode && !res_valid |=> lo_half_q ##1 hi_half_q ##1 !res_valid)
    else $error("unencoded halves out of order");
  miss_zero_a:
    assert property (res_valid && !res_hit |-> res_addr == '0 && res_lines == '0)
    else $error("miss result not zero");
  result_stands_a:
    assert property (!res_valid |-> $stable(res_hit) && $stable(res_addr))
    else $error("result changed between searches");
  upper_follows_a:
    assert property (res_upper |-> res_valid && $past(res_valid) && !$past(res_upper))
    else $error("upper half without lower half");
endmodule : cam_assertions

// >>> verif/content_addressable_memory_block_tb.sv
// Bench joining the user end and the memory end; drives the user side.
// Assumes a 25 MHz clock and the preload given at the memory instance.
`timescale 1ns/1ps
module content_addressable_memory_block_tb;
  logic i_mclk = 1'b0;
  logic i_nrst = 1'b0;
  logic wreq = 1'b0;
  logic sreq = 1'b0;
  logic smode = 1'b0;
  cam_pkg::cam_addr_t waddr = '0;
  cam_pkg::cam_word_t wdata = '0;
  cam_pkg::cam_word_t wcare = '1;
  cam_pkg::cam_word_t sdata = '0;
  logic rdy, rv, rh, ru;
  cam_pkg::cam_addr_t ra;
  logic [15:0] rl;
  int error_cnt = 0;
  int checked = 0;
  int cyc = 0;
  // Row: mode, key, hit, addr, low lines, high lines
  logic [70:0] rows [7];
  initial forever #20 i_mclk = ~i_mclk;
  cam_if cam_if_inst (.i_mclk(i_mclk), .i_nrst(i_nrst));
  cam_mem #(.INIT_DATA('{5: 32'h1234_5678, default: 32'hdead_0000}),
    .INIT_CARE('{default: 32'hffff_ffff})) cam_mem_inst (.bus(cam_if_inst.mem));
  cam_user cam_user_inst (.bus(cam_if_inst.user), .i_wr_req(wreq), .i_wr_addr(waddr),
    .i_wr_data(wdata), .i_wr_care(wcare), .i_srch_req(sreq), .i_srch_mode(smode),
    .i_srch_data(sdata), .o_ready(rdy), .o_res_valid(rv), .o_res_hit(rh),
    .o_res_addr(ra), .o_res_lines(rl), .o_res_upper(ru));
  cam_assertions cam_assertions_inst (.i_mclk(i_mclk), .i_nrst(i_nrst),
    .wr_start(cam_if_inst.wr_start), .wr_addr(cam_if_inst.wr_addr),
    .wr_data(cam_if_inst.wr_data), .wr_care(cam_if_inst.wr_care),
    .wr_busy(cam_if_inst.wr_busy), .srch_start(cam_if_inst.srch_start),
    .srch_mode(cam_if_inst.srch_mode), .res_valid(cam_if_inst.res_valid),
    .res_hit(cam_if_inst.res_hit), .res_addr(cam_if_inst.res_addr),
    .res_lines(cam_if_inst.res_lines), .res_upper(cam_if_inst.res_upper));
  task automatic complete_run();
    if (error_cnt == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : complete_run
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic rdy_wait();
    @(negedge i_mclk);
    while (rdy !== 1'b1) @(negedge i_mclk);
    @(posedge i_mclk);
  endtask : rdy_wait
  task automatic wr(input logic [4:0] a, input logic [31:0] d, input logic [31:0] c);
    rdy_wait();
    wreq <= 1'b1;
    waddr <= a;
    wdata <= d;
    wcare <= c;
    @(posedge i_mclk);
    wreq <= 1'b0;
    // Longest write: one cycle in the user end, three in the memory, one to settle
    repeat (5) @(posedge i_mclk);
  endtask : wr
  task automatic srch(input logic [70:0] r);
    rdy_wait();
    sreq <= 1'b1;
    smode <= r[70];
    sdata <= r[69:38];
    @(posedge i_mclk);
    sreq <= 1'b0;
    @(negedge i_mclk);
    while (rv !== 1'b1) @(negedge i_mclk);
    chk("hit", r[37], rh);
    chk("upper", 0, ru);
    if (r[70]) begin
      chk("lines_lo", r[31:16], rl);
      @(negedge i_mclk);
      chk("upper", 1, ru);
      chk("lines_hi", r[15:0], rl);
    end else begin
      chk("addr", r[36:32], ra);
    end
  endtask : srch
  always @(posedge i_mclk) begin
    cyc++;
    if (cyc == 3000) begin
      error_cnt++;
      complete_run();
    end
  end
  initial begin
    rows = '{{1'h0, 32'h1234_5678, 1'h1, 5'h05, 32'h0}, {1'h0, 32'h0000_00a5, 1'h1, 5'h09, 32'h0},
      {1'h0, 32'h1111_5a77, 1'h1, 5'h14, 32'h0}, {1'h0, 32'h0bad_0bad, 1'h0, 5'h00, 32'h0},
      {1'h1, 32'hdead_0000, 1'h1, 5'h00, 32'hfddf_ffef},
      {1'h1, 32'h1111_5a77, 1'h1, 5'h00, 32'h0000_0010},
      {1'h0, 32'hdead_0000, 1'h1, 5'h00, 32'h0}};
    repeat (3) @(posedge i_mclk);
    i_nrst <= 1'b1;
    wr(5'h09, 32'h0000_00a5, 32'hffff_ffff);
    wr(5'h14, 32'h0000_5a00, 32'h0000_ff00);
    foreach (rows[i]) begin
      srch(rows[i]);
    end
    // Mid-run reset must keep the stored words but clear the valid, hit and upper results
    @(posedge i_mclk);
    i_nrst <= 1'b0;
    repeat (2) @(posedge i_mclk);
    @(negedge i_mclk);
    chk("ready", 32'h0, rdy);
    chk("valid", 32'h0, rv);
    chk("hit", 32'h0, rh);
    chk("upper", 32'h0, ru);
    @(posedge i_mclk);
    i_nrst <= 1'b1;
    srch(rows[1]);
    complete_run();
  end
endmodule : content_addressable_memory_block_tb
